// >>> logic/epr_fifo.sv
// Purpose: step buffer between the scaler and the pulse generator
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty come from a count, never overrun

`timescale 1ns/1ps

module epr_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_L = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_r;
   logic [PW-1:0] rd_r;
   logic [PW:0] cnt_r;
   logic push;
   logic pop;

   // handshakes
   assign in_ready = (cnt_r != DEPTH_L);
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_r];
   assign level = cnt_r;

   // storage
   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= PW'(wr_r + 1'b1);
         end
         if (pop) begin
            rd_r <= PW'(rd_r + 1'b1);
         end
         if (push && !pop) begin
            cnt_r <= (PW+1)'(cnt_r + 1'b1);
         end else if (pop && !push) begin
            cnt_r <= (PW+1)'(cnt_r - 1'b1);
         end
      end
   end

endmodule : epr_fifo

// >>> logic/epr_pkg.sv
// Purpose: shared constants for the encoder pulse reproducer
// Assumes: 20 MHz pclk, APB register access with 32-bit data
// Notes: register offsets are byte addresses, one aligned word each

package epr_pkg;

   // ==========================================================
   // register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_NUM = 8'h00;     // pending numerator
   localparam logic [7:0] REG_DEN = 8'h04;     // pending divisor
   localparam logic [7:0] REG_LOGIC = 8'h08;   // pending logic select
   localparam logic [7:0] REG_LOAD = 8'h0c;    // write 1: power-on load
   localparam logic [7:0] REG_STATUS = 8'h10;  // live state
   localparam logic [7:0] REG_ACTIVE = 8'h14;  // loaded numerator

   // ==========================================================
   // field layout and reset values
   localparam int NUM_W = 19;
   localparam int LOGIC_W = 2;
   localparam logic [NUM_W-1:0] NUM_MAX = 19'h40000;
   localparam logic [NUM_W-1:0] NUM_RST = 19'h00000;
   localparam logic [NUM_W-1:0] DEN_RST = 19'h00000;
   localparam int LOAD_BIT = 0;
   localparam int LOGIC_INV_BIT = 0;
   localparam int LOGIC_SRC_BIT = 1;
   localparam int ST_FC_BIT = 2;
   localparam int ST_SRC_BIT = 3;
   localparam int ST_LVL_LSB = 4;
   localparam int ST_PEND_LSB = 12;

   // ==========================================================
   // scaling and timing
   localparam int ACC_W = 32;
   localparam int PEND_W = 8;
   localparam logic [ACC_W-1:0] QUAD_MULT = 32'h4;
   localparam logic [ACC_W-1:0] ENC_RES_DEF = 32'h100000;
   localparam int EDGE_TIME_NS = 250;          // least spacing of edges
   localparam int CLK_PERIOD_NS = 50;
   localparam int EDGE_CYC =
      (EDGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = 1;                  // 1 = forward step

   // output logic settings
   typedef enum logic [1:0] {
      EPR_ENC_NORM = 2'b00,
      EPR_ENC_INV = 2'b01,
      EPR_SCALE_NORM = 2'b10,
      EPR_SCALE_INV = 2'b11
   } epr_logic_t;

endpackage : epr_pkg

// >>> logic/epr_reproducer.sv
// Purpose: reproduce encoder or scale feedback as quadrature pulses
// Assumes: pins are asynchronous, registers reached over APB
// Notes: starred settings apply only on a power-on load

`timescale 1ns/1ps

module epr_reproducer
   import epr_pkg::*;
#(
   parameter logic [31:0] ENC_RES = epr_pkg::ENC_RES_DEF,
   parameter int DEPTH = epr_pkg::FIFO_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [epr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic enc_index,
   input wire logic scale_a,
   input wire logic scale_b,
   input wire logic full_closed,
   output logic reproduced_phase_a,
   output logic reproduced_phase_b,
   output logic reproduced_index
);
   import epr_pkg::*;

   localparam int LW = $clog2(DEPTH) + 1;
   localparam logic [7:0] GAP_LOAD = 8'(EDGE_CYC - 1);

   // ==========================================================
   // pin synchronisers
   logic [5:0] pin_m_r;
   logic [5:0] pin_s_r;
   logic ea_s, eb_s, ez_s, sa_s, sb_s, fc_s;

   // two flops on every asynchronous pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_m_r <= '0;
         pin_s_r <= '0;
      end else begin
         pin_m_r <= {full_closed, scale_b, scale_a, enc_index, enc_b, enc_a};
         pin_s_r <= pin_m_r;
      end
   end
   assign {fc_s, sb_s, sa_s, ez_s, eb_s, ea_s} = pin_s_r;

   // ==========================================================
   // register file
   logic [NUM_W-1:0] num_p_r, den_p_r, num_a_r, den_a_r;
   logic [LOGIC_W-1:0] logic_p_r;
   epr_logic_t logic_a_r;
   logic wr_en, rd_en, load_pulse, hit;
   logic [31:0] status;
   logic [LW-1:0] fifo_lvl;
   logic signed [PEND_W-1:0] pend_r;
   logic src_scale;

   assign pready = 1'b1;                       // zero wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;  // setup phase
   assign load_pulse = wr_en && (paddr == REG_LOAD) && pwdata[LOAD_BIT];
   assign hit = (paddr == REG_NUM) || (paddr == REG_DEN) ||
                (paddr == REG_LOGIC) || (paddr == REG_LOAD) ||
                (paddr == REG_STATUS) || (paddr == REG_ACTIVE);
   assign pslverr = psel && penable && !hit;  // unmapped address

   // pending settings, written freely, numerator and divisor above range clamp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         num_p_r <= NUM_RST;
         den_p_r <= DEN_RST;
         logic_p_r <= EPR_ENC_NORM;
      end else if (wr_en) begin
         if (paddr == REG_NUM) begin
            num_p_r <= (pwdata > 32'(NUM_MAX)) ? NUM_MAX : pwdata[NUM_W-1:0];
         end
         if (paddr == REG_DEN) begin
            den_p_r <= (pwdata > 32'(NUM_MAX)) ? NUM_MAX : pwdata[NUM_W-1:0];
         end
         if (paddr == REG_LOGIC) begin
            logic_p_r <= pwdata[LOGIC_W-1:0];
         end
      end
   end

   // active settings, copied only by the power-on load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         num_a_r <= NUM_RST;
         den_a_r <= DEN_RST;
         logic_a_r <= EPR_ENC_NORM;
      end else if (load_pulse) begin
         num_a_r <= num_p_r;
         den_a_r <= den_p_r;
         logic_a_r <= epr_logic_t'(logic_p_r);
      end
   end

   assign status = {{(32-ST_PEND_LSB-PEND_W){1'b0}}, pend_r,
                    {(ST_PEND_LSB-ST_LVL_LSB-LW){1'b0}}, fifo_lvl,
                    src_scale, fc_s, logic_a_r};

   // read data loaded at setup, standing through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_en) begin
         unique case (paddr)
            REG_NUM: prdata <= 32'(num_p_r);
            REG_DEN: prdata <= 32'(den_p_r);
            REG_LOGIC: prdata <= 32'(logic_p_r);
            REG_STATUS: prdata <= status;
            REG_ACTIVE: prdata <= 32'(num_a_r);
            default: prdata <= '0;
         endcase
      end
   end

   // ==========================================================
   // source select and quadrature decode
   logic [1:0] qin_r;
   logic [1:0] qcur;
   logic in_step, in_fwd;

   assign src_scale = logic_a_r[LOGIC_SRC_BIT] && fc_s;
   assign qcur = src_scale ? {sa_s, sb_s} : {ea_s, eb_s};

   // previous decoded phase pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qin_r <= '0;
      end else begin
         qin_r <= qcur;
      end
   end

   // one count per state change; forward when A leads B
   always_comb begin
      in_step = 1'b0;
      in_fwd = 1'b0;
      if ((qcur[1] ^ qin_r[1]) != (qcur[0] ^ qin_r[0])) begin
         in_step = 1'b1;
         in_fwd = (qin_r[1] ^ qin_r[0]) ? (qcur[1] == qin_r[1])
                                          : (qcur[0] == qin_r[0]);
      end
   end

   // ==========================================================
   // ratio selection
   logic [ACC_W-1:0] num_raw, num_eff, den_eff;

   // effective numerator and denominator of the step ratio
   always_comb begin
      if (den_a_r == '0 && src_scale) begin
         num_raw = 32'h1;
         den_eff = 32'h1;
      end else if (den_a_r == '0) begin
         num_raw = 32'(num_a_r) * QUAD_MULT;
         den_eff = ENC_RES;
      end else begin
         num_raw = 32'(num_a_r);
         den_eff = 32'(den_a_r);
      end
      num_eff = (num_raw > den_eff) ? den_eff : num_raw;
   end

   // ==========================================================
   // pending counts and remainder accumulator
   logic [ACC_W-1:0] acc_r, acc_nxt, sum;
   logic consume, emit, cons_fwd, fifo_in_ready;
   logic signed [PEND_W-1:0] pend_nxt;
   logic src_q_r;

   assign consume = (pend_r != '0) && fifo_in_ready;
   assign cons_fwd = !pend_r[PEND_W-1];
   assign sum = ACC_W'(acc_r + num_eff);

   // step through one pending count when the buffer can take it
   always_comb begin
      acc_nxt = acc_r;
      emit = 1'b0;
      if (consume && cons_fwd) begin
         if (sum >= den_eff) begin
            acc_nxt = ACC_W'(sum - den_eff);
            emit = 1'b1;
         end else begin
            acc_nxt = sum;
         end
      end else if (consume) begin
         if (acc_r >= num_eff) begin
            acc_nxt = ACC_W'(acc_r - num_eff);
         end else begin
            acc_nxt = ACC_W'(acc_r + den_eff - num_eff);
            emit = 1'b1;
         end
      end
   end

   // net counts waiting while the buffer is full
   always_comb begin
      pend_nxt = pend_r;
      if (in_step && in_fwd) begin
         pend_nxt = PEND_W'(pend_nxt + 1);
      end else if (in_step) begin
         pend_nxt = PEND_W'(pend_nxt - 1);
      end
      if (consume && cons_fwd) begin
         pend_nxt = PEND_W'(pend_nxt - 1);
      end else if (consume) begin
         pend_nxt = PEND_W'(pend_nxt + 1);
      end
   end

   // accumulator restarts on a new ratio or a change of source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= '0;
         pend_r <= '0;
         src_q_r <= 1'b0;
      end else begin
         src_q_r <= src_scale;
         acc_r <= (load_pulse || src_q_r != src_scale) ? '0 : acc_nxt;
         pend_r <= pend_nxt;
      end
   end

   // ==========================================================
   // step buffer
   logic out_valid, out_fwd, out_ready;

   epr_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(emit),
      .in_ready(fifo_in_ready),
      .in_data(cons_fwd),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_fwd),
      .level(fifo_lvl)
   );

   // ==========================================================
   // quadrature output generator
   logic [1:0] qs_r, qs_nxt;
   logic [7:0] gap_r;
   logic pop;

   assign out_ready = (gap_r == '0);
   assign pop = out_valid && out_ready;
   assign qs_nxt = !pop ? qs_r : out_fwd ? 2'(qs_r + 1'b1)
                                         : 2'(qs_r - 1'b1);

   // gray sequence, one edge per step, spaced by the edge time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qs_r <= '0;
         gap_r <= '0;
      end else begin
         qs_r <= qs_nxt;
         gap_r <= pop ? GAP_LOAD : (out_ready ? gap_r : 8'(gap_r - 1'b1));
      end
   end

   // registered pins; index passes through unaligned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reproduced_phase_a <= 1'b0;
         reproduced_phase_b <= 1'b0;
         reproduced_index <= 1'b0;
      end else begin
         reproduced_phase_a <= qs_nxt[1] ^ qs_nxt[0];  // a leads forward unless B is inverted
         reproduced_phase_b <= qs_nxt[1] ^
                               logic_a_r[LOGIC_INV_BIT];
         reproduced_index <= ez_s;
      end
   end

   // ==========================================================
   // checks
   quad_one_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(qs_r) && $past(logic_a_r) == $past(logic_a_r, 2) |->
      $changed(reproduced_phase_a) != $changed(reproduced_phase_b))
      else $error("both phases changed together");

   edge_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      pop |=> !pop [*4])
      else $error("output edges closer than the edge time");

   phase_b_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
      reproduced_phase_b == (qs_r[1] ^
                             $past(logic_a_r[LOGIC_INV_BIT])))
      else $error("phase B polarity wrong");

   active_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !load_pulse |=> $stable(logic_a_r) && $stable(num_a_r) &&
      $stable(den_a_r))
      else $error("active setting changed without load");

   enc_default_a: assert property (@(posedge pclk) disable iff (!presetn)
      !fc_s |-> !src_scale)
      else $error("scale source without full-closed control");

   res_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
      num_eff <= den_eff && (den_eff == '0 || acc_r < den_eff ||
      $past(load_pulse) || $changed(den_eff)))
      else $error("ratio above one or remainder out of range");

   enc_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
      (den_a_r == '0 && !src_scale && 32'(num_a_r) * QUAD_MULT <= ENC_RES)
      |-> num_eff == 32'(num_a_r) * QUAD_MULT && den_eff == ENC_RES)
      else $error("encoder ratio not numerator times four");

   scale_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      (den_a_r == '0 && src_scale && consume) |-> emit)
      else $error("scale pulse not passed one for one");

   div_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
      (den_a_r != '0 && num_a_r <= den_a_r) |->
      num_eff == 32'(num_a_r) && den_eff == 32'(den_a_r))
      else $error("divisor ratio not applied");

endmodule : epr_reproducer

// >>> testbench/epr_host_counter.sv
// Purpose: host side counter of reproduced quadrature pulses
// Assumes: outputs registered on pclk, A leading B counts up
// Notes: clear zeroes both counts; every level change is one edge

`timescale 1ns/1ps

module epr_host_counter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic phase_a,
   input wire logic phase_b,
   output int pos,
   output int edges
);
   logic [1:0] prev_r;
   logic [1:0] cur;

   assign cur = {phase_a, phase_b};

   // ==========================================================
   // quadrature decode, one count per change of either phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 2'h0;
         pos <= 0;
         edges <= 0;
      end else begin
         prev_r <= cur;
         if (clear) begin
            pos <= 0;
            edges <= 0;
         end else if (cur != prev_r) begin
            edges <= edges + 1;
            if (cur == {~prev_r[0], prev_r[1]}) begin
               pos <= pos + 1;
            end else begin
               pos <= pos - 1;
            end
         end
      end
   end
endmodule : epr_host_counter

// >>> testbench/epr_reproducer_tb_top.sv
// Purpose: register and pulse scaling checks of the reproducer
// Assumes: 20 MHz pclk, small encoder resolution for short runs
// Notes: inputs step every 8 clocks, well under the output rate

`timescale 1ns/1ps

module epr_reproducer_tb_top;
   import epr_pkg::*;
   localparam logic [31:0] RES = 32'h40;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic enc_a = 1'b0, enc_b = 1'b0, enc_index = 1'b0;
   logic scale_a = 1'b0, scale_b = 1'b0, full_closed = 1'b0;
   logic out_a, out_b, out_z;
   logic clear = 1'b0;
   int pos, edges, miscompares = 0, samples_checked = 0;
   int ref_dir;
   logic [31:0] rd;
   logic err;
   int q_enc = 0, q_scl = 0;
   logic [1:0] seq [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
   // ratio cases: num, den, code, full_closed, scale moves, count, edges
   int cn [6] = '{8, 8, 3, 8, 8, 3};
   int cd [6] = '{0, 0, 4, 4, 0, 4};
   int cc [6] = '{0, 2, 0, 0, 0, 2};
   int cf [6] = '{0, 1, 0, 0, 0, 1};
   int cs [6] = '{0, 1, 0, 0, 1, 1};
   int ck [6] = '{64, 20, 40, 20, 20, 40};
   int ce [6] = '{32, 20, 30, 20, 0, 30};

   always #25 pclk = ~pclk;

   epr_reproducer #(.ENC_RES(RES), .DEPTH(FIFO_DEPTH)) u_epr_reproducer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
      .enc_index(enc_index), .scale_a(scale_a), .scale_b(scale_b),
      .full_closed(full_closed), .reproduced_phase_a(out_a),
      .reproduced_phase_b(out_b), .reproduced_index(out_z));

   epr_host_counter u_epr_host_counter (
      .clk(pclk), .rst_n(presetn), .clear(clear), .phase_a(out_a),
      .phase_b(out_b), .pos(pos), .edges(edges));

   // ==========================================================
   // checking and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         report_and_stop();
      end
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      rd = prdata;
   endtask : apb

   // settings, power-on load, then counter cleared
   task automatic setup(input int n, input int d, input int c);
      apb(1'b1, REG_NUM, n);
      apb(1'b1, REG_DEN, d);
      apb(1'b1, REG_LOGIC, c);
      apb(1'b1, REG_LOAD, 32'h1);
      repeat (10) @(posedge pclk);
      clear <= 1'b1;
      @(posedge pclk);
      clear <= 1'b0;
   endtask : setup

   // input steps, A leading B when forward
   task automatic run(input bit scl, input bit fwd, input int k);
      repeat (k) begin
         @(posedge pclk);
         if (scl) begin
            q_scl = (q_scl + (fwd ? 1 : 3)) % 4;
            {scale_a, scale_b} <= seq[q_scl];
         end else begin
            q_enc = (q_enc + (fwd ? 1 : 3)) % 4;
            {enc_a, enc_b} <= seq[q_enc];
         end
         repeat (7) @(posedge pclk);
      end
   endtask : run

   task automatic drain(input int exp);
      int n;
      n = 0;
      while (edges < exp && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 2000) begin
         miscompares++;
         report_and_stop();
      end
      repeat (40) @(posedge pclk);
   endtask : drain

   // ==========================================================
   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk(out_z, 1'b0);
      apb(1'b0, REG_NUM, 0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h0);
      apb(1'b0, REG_DEN, 0);
      chk(rd, 32'h0);
      apb(1'b0, REG_LOGIC, 0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, REG_NUM, 32'h7ffff);
      apb(1'b0, REG_NUM, 0);
      chk(rd, 32'h40000);
      // pending values stay unused until the load
      apb(1'b1, REG_NUM, 32'h8);
      apb(1'b1, REG_LOGIC, 32'h1);
      apb(1'b0, REG_ACTIVE, 0);
      chk(rd, 32'h0);
      apb(1'b0, REG_STATUS, 0);
      chk({30'h0, rd[1:0]}, 32'h0);
      apb(1'b1, REG_LOAD, 32'h1);
      apb(1'b0, REG_ACTIVE, 0);
      chk(rd, 32'h8);
      apb(1'b0, REG_STATUS, 0);
      chk({30'h0, rd[1:0]}, 32'h1);
      // ratio table
      for (int i = 0; i < 6; i++) begin
         if (cf[i] != 0) begin
            full_closed <= 1'b1;
         end
         setup(cn[i], cd[i], cc[i]);
         full_closed <= cf[i][0];
         run(cs[i][0], 1'b1, ck[i]);
         drain(ce[i]);
         chk(edges, ce[i]);
      end
      // every logic code, one to one, forward; then code 0 in reverse
      full_closed <= 1'b1;
      ref_dir = 0;
      for (int c = 0; c < 4; c++) begin
         setup(1, 1, c);
         apb(1'b0, REG_STATUS, 0);
         chk({31'h0, rd[ST_SRC_BIT]}, c / 2);
         run(c >= 2, 1'b1, 8);
         drain(8);
         if (c == 0) begin
            ref_dir = pos;
         end
         chk(edges, 8);
         chk(pos, (c % 2) ? -8 : 8);
      end
      chk(ref_dir, 8);
      setup(1, 1, 0);
      run(1'b0, 1'b0, 8);
      drain(8);
      chk(pos, -8);
      // index passed through
      enc_index <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(out_z, 1'b1);
      report_and_stop();
   end
endmodule : epr_reproducer_tb_top
